//--- pds_map.vh
`ifndef PDS_MAP_VH
`define PDS_MAP_VH

// register offsets
`define PDS_OFS_DISCHARGE_3 8'h42
`define PDS_OFS_PG_DELAY_1 8'h43
`define PDS_OFS_SHUTDOWN 8'h91
`define PDS_OFS_SLEEP_1 8'h92

// field positions
`define PDS_LINEAR_THREE_LSB 0
`define PDS_SWITCH_ONE_LSB 2
`define PDS_SWITCH_TWO_LSB 4
`define PDS_DELAY_MSB 2
`define PDS_OFF_BIT 0
`define PDS_SLEEP_EN_BIT 0
`define PDS_SLEEP_CODE_MSB 7
`define PDS_SLEEP_CODE_LSB 1

// reset values, and the no-discharge code forced while a rail is enabled
`define PDS_RST_DISCHARGE_3 6'h15
`define PDS_RST_PG_DELAY_1 3'h0
`define PDS_RST_SHUTDOWN 8'h00
`define PDS_RST_SLEEP_CODE 7'h00
`define PDS_RST_SLEEP_EN 1'b0
`define PDS_NO_DISCHARGE 2'h0

// bus address of the device, value arbitrary
`define PDS_BUS_ADDR 7'h2a

// rails grouped to output three, one bit per rail
`define PDS_GROUP_MASK 8'h0f

// output three modes
`define PDS_MODE_PG 2'h0
`define PDS_MODE_LEVEL 2'h1
`define PDS_MODE_BUS 2'h2

// timing
`define PDS_CLK_MHZ 20
`define PDS_DLY_000_US 2500
`define PDS_DLY_001_US 5000
`define PDS_DLY_010_US 10000
`define PDS_DLY_011_US 15000
`define PDS_DLY_100_US 20000
`define PDS_DLY_101_US 50000
`define PDS_DLY_111_US 100000

`endif

//--- pds_i2c_slave.v
`timescale 1ns/1ps
`include "pds_map.vh"

module pds_i2c_slave (
  input wire sys_clk,
  input wire rst_n,
  input wire abort,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output reg sda_oe_n,
  output reg [7:0] reg_ptr,
  output reg [7:0] wr_data,
  output reg wr_stb,
  input wire suppress_ack,
  input wire [7:0] rd_data
);
  localparam ST_IDLE = 3'd0;
  localparam ST_RX = 3'd1;
  localparam ST_ACK = 3'd2;
  localparam ST_TX = 3'd3;
  localparam ST_RACK = 3'd4;
  localparam PH_ADDR = 2'd0;
  localparam PH_PTR = 2'd1;
  localparam PH_DATA = 2'd2;

  reg scl_s1, scl_s2, scl_d;
  reg sda_s1, sda_s2, sda_d;
  reg [2:0] state;
  reg [1:0] phase;
  reg [3:0] bitcnt;
  reg [7:0] shreg;
  reg reading;
  reg acked;

  wire scl_rise = scl_s2 & ~scl_d;
  wire scl_fall = ~scl_s2 & scl_d;
  wire start_seen = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire stop_seen = scl_s2 & scl_d & ~sda_d & sda_s2;

  // open drain: only ever pulls low
  assign sda_out = 1'b0;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      phase <= PH_ADDR;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      reading <= 1'b0;
      acked <= 1'b0;
      sda_oe_n <= 1'b1;
      reg_ptr <= 8'h00;
      wr_data <= 8'h00;
      wr_stb <= 1'b0;
    end else if (abort) begin
      state <= ST_IDLE;
      sda_oe_n <= 1'b1;
      wr_stb <= 1'b0;
      reg_ptr <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (start_seen) begin
        state <= ST_RX;
        phase <= PH_ADDR;
        bitcnt <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (stop_seen) begin
        state <= ST_IDLE;
        sda_oe_n <= 1'b1;
      end else begin
        case (state)
          ST_RX: begin
            if (scl_rise && bitcnt != 4'h8) begin
              shreg <= {shreg[6:0], sda_s2};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              state <= ST_ACK;
              acked <= 1'b1;
              sda_oe_n <= 1'b0;
              if (phase == PH_ADDR) begin
                reading <= shreg[0];
                if (shreg[7:1] != `PDS_BUS_ADDR) begin
                  acked <= 1'b0;
                  sda_oe_n <= 1'b1;
                end
              end else if (phase == PH_PTR) begin
                reg_ptr <= shreg;
              end else begin
                wr_data <= shreg;
                wr_stb <= 1'b1;
                // judge the byte just shifted in, wr_data still holds the previous one
                if (suppress_ack && shreg[`PDS_OFF_BIT]) begin
                  acked <= 1'b0;
                  sda_oe_n <= 1'b1;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              sda_oe_n <= 1'b1;
              bitcnt <= 4'h0;
              if (!acked) begin
                state <= ST_IDLE;
              end else if (phase == PH_ADDR && reading) begin
                state <= ST_TX;
                shreg <= {rd_data[6:0], 1'b0};
                sda_oe_n <= rd_data[7];
                bitcnt <= 4'h1;
                phase <= PH_DATA;
              end else begin
                state <= ST_RX;
                if (phase == PH_DATA) begin
                  reg_ptr <= reg_ptr + 8'h01;
                end
                phase <= (phase == PH_ADDR) ? PH_PTR : PH_DATA;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bitcnt == 4'h8) begin
                sda_oe_n <= 1'b1;
                state <= ST_RACK;
                reg_ptr <= reg_ptr + 8'h01;
              end else begin
                sda_oe_n <= shreg[7];
                shreg <= {shreg[6:0], 1'b0};
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              acked <= ~sda_s2;
            end else if (scl_fall) begin
              if (acked) begin
                state <= ST_TX;
                shreg <= {rd_data[6:0], 1'b0};
                sda_oe_n <= rd_data[7];
                bitcnt <= 4'h1;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_IDLE: begin
            sda_oe_n <= 1'b1;
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule

//--- pds_regs.v
`timescale 1ns/1ps
`include "pds_map.vh"

module pds_regs #(
  parameter [20:0] DLY_000_CYC = `PDS_DLY_000_US * `PDS_CLK_MHZ,
  parameter [20:0] DLY_001_CYC = `PDS_DLY_001_US * `PDS_CLK_MHZ,
  parameter [20:0] DLY_010_CYC = `PDS_DLY_010_US * `PDS_CLK_MHZ,
  parameter [20:0] DLY_011_CYC = `PDS_DLY_011_US * `PDS_CLK_MHZ,
  parameter [20:0] DLY_100_CYC = `PDS_DLY_100_US * `PDS_CLK_MHZ,
  parameter [20:0] DLY_101_CYC = `PDS_DLY_101_US * `PDS_CLK_MHZ,
  parameter [20:0] DLY_111_CYC = `PDS_DLY_111_US * `PDS_CLK_MHZ
) (
  input wire sys_clk,
  input wire reset_n,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_n,
  input wire [2:0] rail_enabled,
  output wire [5:0] discharge_sel,
  input wire [7:0] rail_in_regulation,
  input wire level_shift_in,
  input wire [1:0] output_three_mode,
  input wire output_three_feeds_vtt,
  input wire output_three_bus_level,
  output reg general_output_three,
  input wire sleep_pin_a,
  input wire sleep_pin_b,
  input wire sleep_pin_select,
  input wire [6:0] rail_one_normal_voltage_code,
  output reg [6:0] rail_one_voltage_code,
  output reg emergency_off
);
  reg rst_s1, rst_s2;
  wire rst_n = rst_s2;

  // level inputs from outside the clock domain
  reg [2:0] en_s1, en_s2;
  reg [7:0] reg_s1, reg_s2;
  reg lvl_s1, lvl_s2;
  reg slp_a_s1, slp_a_s2;
  reg slp_b_s1, slp_b_s2;

  reg [5:0] discharge_fields;
  reg [2:0] output_three_goodness_delay;
  reg [6:0] rail_one_sleep_voltage_code;
  reg rail_one_sleep_enable;
  reg emergency_off_cmd;
  reg soft_reset;

  reg [20:0] delay_cnt;
  reg [20:0] delay_target;
  reg [7:0] read_mux;

  wire [7:0] reg_ptr;
  wire [7:0] wr_data;
  wire wr_stb;
  wire off_request = (reg_ptr == `PDS_OFS_SHUTDOWN);
  wire [5:0] dis_rst = `PDS_RST_DISCHARGE_3;
  wire group_good = &(reg_s2 | ~`PDS_GROUP_MASK);
  wire bus_driven = (output_three_mode == `PDS_MODE_BUS) & ~output_three_feeds_vtt;
  wire delay_source = (output_three_mode == `PDS_MODE_LEVEL) ? lvl_s2 : group_good;
  wire sleep_pin = sleep_pin_select ? slp_b_s2 : slp_a_s2;

  assign discharge_sel = discharge_fields;

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_s1 <= 3'h0;
      en_s2 <= 3'h0;
      reg_s1 <= 8'h00;
      reg_s2 <= 8'h00;
      lvl_s1 <= 1'b0;
      lvl_s2 <= 1'b0;
      slp_a_s1 <= 1'b1;
      slp_a_s2 <= 1'b1;
      slp_b_s1 <= 1'b1;
      slp_b_s2 <= 1'b1;
    end else begin
      en_s1 <= rail_enabled;
      en_s2 <= en_s1;
      reg_s1 <= rail_in_regulation;
      reg_s2 <= reg_s1;
      lvl_s1 <= level_shift_in;
      lvl_s2 <= lvl_s1;
      slp_a_s1 <= sleep_pin_a;
      slp_a_s2 <= slp_a_s1;
      slp_b_s1 <= sleep_pin_b;
      slp_b_s2 <= slp_b_s1;
    end
  end

  pds_i2c_slave u_slave (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .abort(soft_reset),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .reg_ptr(reg_ptr),
    .wr_data(wr_data),
    .wr_stb(wr_stb),
    .suppress_ack(off_request),
    .rd_data(read_mux)
  );

  // discharge fields: 0 rail three linear, 1 switch one, 2 switch two
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_dis
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          discharge_fields[2*g+1:2*g] <= dis_rst[2*g+1:2*g];
        end else if (soft_reset) begin
          discharge_fields[2*g+1:2*g] <= dis_rst[2*g+1:2*g];
        end else if (en_s2[g]) begin
          // enable wins over a same-cycle write
          discharge_fields[2*g+1:2*g] <= `PDS_NO_DISCHARGE;
        end else if (wr_stb && reg_ptr == `PDS_OFS_DISCHARGE_3) begin
          discharge_fields[2*g+1:2*g] <= wr_data[2*g+1:2*g];
        end
      end
    end
  endgenerate

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      output_three_goodness_delay <= `PDS_RST_PG_DELAY_1;
      rail_one_sleep_voltage_code <= `PDS_RST_SLEEP_CODE;
      rail_one_sleep_enable <= `PDS_RST_SLEEP_EN;
      emergency_off_cmd <= 1'b0;
      soft_reset <= 1'b0;
      emergency_off <= 1'b0;
    end else if (soft_reset) begin
      output_three_goodness_delay <= `PDS_RST_PG_DELAY_1;
      rail_one_sleep_voltage_code <= `PDS_RST_SLEEP_CODE;
      rail_one_sleep_enable <= `PDS_RST_SLEEP_EN;
      emergency_off_cmd <= 1'b0;
      soft_reset <= 1'b0;
      emergency_off <= 1'b0;
    end else begin
      emergency_off_cmd <= 1'b0;
      emergency_off <= 1'b0;
      if (wr_stb) begin
        case (reg_ptr)
          `PDS_OFS_PG_DELAY_1: begin
            output_three_goodness_delay <= wr_data[`PDS_DELAY_MSB:0];
          end
          `PDS_OFS_SHUTDOWN: begin
            // only bit 0 acts; a 0 does nothing
            if (wr_data[`PDS_OFF_BIT]) begin
              emergency_off_cmd <= 1'b1;
              emergency_off <= 1'b1;
              soft_reset <= 1'b1;
            end
          end
          `PDS_OFS_SLEEP_1: begin
            rail_one_sleep_voltage_code <= wr_data[`PDS_SLEEP_CODE_MSB:`PDS_SLEEP_CODE_LSB];
            rail_one_sleep_enable <= wr_data[`PDS_SLEEP_EN_BIT];
          end
          default: begin
            output_three_goodness_delay <= output_three_goodness_delay;
          end
        endcase
      end
    end
  end

  always @* begin
    case (output_three_goodness_delay)
      3'h0: delay_target = DLY_000_CYC;
      3'h1: delay_target = DLY_001_CYC;
      3'h2: delay_target = DLY_010_CYC;
      3'h3: delay_target = DLY_011_CYC;
      3'h4: delay_target = DLY_100_CYC;
      3'h5: delay_target = DLY_101_CYC;
      default: delay_target = DLY_111_CYC;
    endcase
  end

  // output asserts delay_target cycles after the source goes high
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      delay_cnt <= 21'h000000;
      general_output_three <= 1'b0;
    end else if (soft_reset) begin
      delay_cnt <= 21'h000000;
      general_output_three <= 1'b0;
    end else if (bus_driven) begin
      delay_cnt <= 21'h000000;
      general_output_three <= output_three_bus_level;
    end else if (!delay_source) begin
      delay_cnt <= 21'h000000;
      general_output_three <= 1'b0;
    end else if (delay_cnt >= delay_target - 21'h000001) begin
      general_output_three <= 1'b1;
    end else begin
      delay_cnt <= delay_cnt + 21'h000001;
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rail_one_voltage_code <= 7'h00;
    end else if (rail_one_sleep_enable && !sleep_pin) begin
      rail_one_voltage_code <= rail_one_sleep_voltage_code;
    end else begin
      rail_one_voltage_code <= rail_one_normal_voltage_code;
    end
  end

  // reserved bits read zero
  always @* begin
    case (reg_ptr)
      `PDS_OFS_DISCHARGE_3: read_mux = {2'h0, discharge_fields};
      `PDS_OFS_PG_DELAY_1: read_mux = {5'h00, output_three_goodness_delay};
      `PDS_OFS_SHUTDOWN: read_mux = {7'h00, emergency_off_cmd};
      `PDS_OFS_SLEEP_1: read_mux = {rail_one_sleep_voltage_code, rail_one_sleep_enable};
      default: read_mux = `PDS_RST_SHUTDOWN;
    endcase
  end
endmodule

//--- pds_regs_sva.sv
`timescale 1ns/1ps
module pds_regs_sva #(
  parameter [20:0] DLY_000_CYC = 21'd50000
) (
  input wire sys_clk,
  input wire reset_n,
  input wire sda_oe_n,
  input wire [2:0] rail_enabled,
  input wire [5:0] discharge_sel,
  input wire [7:0] rail_in_regulation,
  input wire [1:0] output_three_mode,
  input wire output_three_feeds_vtt,
  input wire output_three_bus_level,
  input wire general_output_three,
  input wire sleep_pin_a,
  input wire sleep_pin_b,
  input wire sleep_pin_select,
  input wire [6:0] rail_one_normal_voltage_code,
  input wire [6:0] rail_one_voltage_code,
  input wire emergency_off
);
  logic [3:0] up_cnt;
  logic [20:0] reg_cnt;
  wire rdy = &up_cnt;
  wire all_reg = &rail_in_regulation[3:0];
  wire pin_lvl = sleep_pin_select ? sleep_pin_b : sleep_pin_a;
  // soft reset after shutdown restarts the settle window too
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      up_cnt <= 4'h0;
      reg_cnt <= 21'h0;
    end else begin
      up_cnt <= emergency_off ? 4'h0 : (rdy ? up_cnt : up_cnt + 4'h1);
      reg_cnt <= all_reg ? reg_cnt + 21'h1 : 21'h0;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_reset_outputs: assert property ($rose(reset_n) |-> discharge_sel == 6'h15
    && !general_output_three && rail_one_voltage_code == 7'h00 && !emergency_off) else $error("reset values");
  a_linear_forced: assert property ((rdy && rail_enabled[0]) [*4] |-> discharge_sel[1:0] == 2'h0)
    else $error("linear field not forced");
  a_switch_forced: assert property ((rdy && rail_enabled[2]) [*4] |-> discharge_sel[5:4] == 2'h0)
    else $error("switch field not forced");
  a_pg_held_off: assert property ((rdy && output_three_mode == 2'h0 && !all_reg) [*4]
    |-> !general_output_three) else $error("output three without regulation");
  a_pg_not_early: assert property (output_three_mode == 2'h0 && $rose(general_output_three)
    |-> reg_cnt >= DLY_000_CYC - 21'd3) else $error("output three early");
  a_bus_follows: assert property ((rdy && output_three_mode == 2'h2 && !output_three_feeds_vtt
    && $stable(output_three_bus_level)) [*3] |-> general_output_three == output_three_bus_level)
    else $error("bus level not followed");
  a_sleep_normal: assert property ((rdy && pin_lvl && $stable(rail_one_normal_voltage_code)) [*5]
    |-> rail_one_voltage_code == rail_one_normal_voltage_code) else $error("normal code not used");
  a_off_single: assert property (emergency_off |=> !emergency_off) else $error("shutdown pulse long");
  a_off_restores: assert property (emergency_off && rail_enabled == 3'h0
    |-> ##[1:4] discharge_sel == 6'h15) else $error("registers not restored");
  a_off_no_ack: assert property ($rose(emergency_off) |-> sda_oe_n [*8]) else $error("ack on shutdown");
  cover property ($rose(general_output_three));
  cover property (emergency_off);
  cover property ($fell(sda_oe_n));
endmodule
bind pds_regs pds_regs_sva #(.DLY_000_CYC(DLY_000_CYC)) u_sva (.sys_clk, .reset_n, .sda_oe_n, .rail_enabled,
  .discharge_sel, .rail_in_regulation, .output_three_mode, .output_three_feeds_vtt, .output_three_bus_level,
  .general_output_three, .sleep_pin_a, .sleep_pin_b, .sleep_pin_select, .rail_one_normal_voltage_code,
  .rail_one_voltage_code, .emergency_off);

//--- pds_host_model.sv
`timescale 1ns/1ps
`include "pds_map.vh"
module pds_host_model #(
  parameter int Q = 2
) (
  input wire clk,
  input wire sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task q;
    repeat (Q) @(posedge clk);
  endtask
  task bitx(input logic b, output logic r);
    sda_low <= !b;
    q;
    scl <= 1'b1;
    q;
    q;
    r = sda;
    scl <= 1'b0;
    q;
  endtask
  task start;
    sda_low <= 1'b0;
    q;
    scl <= 1'b1;
    q;
    sda_low <= 1'b1;
    q;
    scl <= 1'b0;
    q;
  endtask
  task stop;
    sda_low <= 1'b1;
    q;
    scl <= 1'b1;
    q;
    sda_low <= 1'b0;
    q;
  endtask
  task xfer(input logic [7:0] d, output logic [7:0] r, output logic ack);
    logic n;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r[i]);
    bitx(1'b1, n);
    ack = !n;
  endtask
  // a missing ack is not an error here, the stop still follows
  task wr(input logic [7:0] a, input logic [7:0] d, output logic ack);
    logic [7:0] r;
    start;
    xfer({`PDS_BUS_ADDR, 1'b0}, r, ack);
    xfer(a, r, ack);
    xfer(d, r, ack);
    stop;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    logic k;
    start;
    xfer({`PDS_BUS_ADDR, 1'b0}, d, k);
    xfer(a, d, k);
    start;
    xfer({`PDS_BUS_ADDR, 1'b1}, d, k);
    xfer(8'hff, d, k);
    stop;
  endtask
endmodule

//--- pds_regs_tb_top.sv
`timescale 1ns/1ps
module pds_regs_tb_top;
  logic sys_clk, reset_n, scl, sda_low, ack, lvl_in, vtt, bus_lvl, pin_a, pin_b, pin_sel, go3, e_off, oe_n;
  logic [2:0] rail_en;
  logic [7:0] in_reg, rd, d;
  logic [1:0] mode;
  logic [6:0] norm, vcode;
  logic [5:0] dsel;
  logic [7:0] ra[5] = '{8'h42, 8'h43, 8'h91, 8'h92, 8'h50};
  logic [7:0] rv[5] = '{8'h15, 8'h00, 8'h00, 8'h00, 8'h00};
  integer seed = 96, failures = 0, num_checks = 0, n;
  wire sda = !(sda_low || oe_n === 1'b0);
  pds_regs #(.DLY_000_CYC(21'd10), .DLY_001_CYC(21'd20), .DLY_010_CYC(21'd40), .DLY_011_CYC(21'd60),
    .DLY_100_CYC(21'd80), .DLY_101_CYC(21'd200), .DLY_111_CYC(21'd400)) u_dut (.sys_clk(sys_clk),
    .reset_n(reset_n), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe_n(oe_n), .rail_enabled(rail_en),
    .discharge_sel(dsel), .rail_in_regulation(in_reg), .level_shift_in(lvl_in), .output_three_mode(mode),
    .output_three_feeds_vtt(vtt), .output_three_bus_level(bus_lvl), .general_output_three(go3),
    .sleep_pin_a(pin_a), .sleep_pin_b(pin_b), .sleep_pin_select(pin_sel), .rail_one_normal_voltage_code(norm),
    .rail_one_voltage_code(vcode), .emergency_off(e_off));
  pds_host_model u_host (.clk(sys_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  function automatic int dly(input logic [2:0] c);
    int t[8] = '{10, 20, 40, 60, 80, 200, 400, 400};
    return t[c];
  endfunction
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task final_report;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task cy(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  // mode and pin select are straps, so they only move under reset
  task rst(input logic [1:0] m, input logic s);
    cy(1);
    reset_n <= 1'b0;
    mode <= m;
    pin_sel <= s;
    vtt <= 1'b0;
    cy(8);
    reset_n <= 1'b1;
    cy(8);
  endtask
  task wr8(input logic [7:0] a, input logic [7:0] v);
    u_host.wr(a, v, ack);
    chk("ack", {7'h0, ack}, {7'h0, !(a == 8'h91 && v[0])});
  endtask
  task defaults;
    for (int i = 0; i < 5; i++) begin
      u_host.rd(ra[i], rd);
      chk("default", rd, rv[i]);
    end
  endtask
  task sleep_run;
    logic [6:0] sc;
    sc = 7'($random(seed));
    norm <= 7'($random(seed));
    for (int e = 1; e >= 0; e--) begin
      wr8(8'h92, {sc, 1'(e)});
      u_host.rd(8'h92, rd);
      chk("sleep reg", rd, {sc, 1'(e)});
      for (int k = 0; k < 4; k++) begin
        pin_a <= k[0];
        pin_b <= k[1];
        cy(6);
        chk("rail code", {1'b0, vcode}, {1'b0, (e && !(pin_sel ? k[1] : k[0])) ? sc : norm});
      end
    end
  endtask
  initial begin
    #4000000;
    failures++;
    final_report;
  end
  initial begin
    reset_n = 1'b0;
    rail_en = 3'h0;
    in_reg = 8'h00;
    lvl_in = 1'b0;
    vtt = 1'b0;
    bus_lvl = 1'b0;
    pin_a = 1'b1;
    pin_b = 1'b1;
    pin_sel = 1'b0;
    mode = 2'h0;
    norm = 7'h33;
    rst(2'h0, 1'b0);
    chk("dsel reset", {2'b00, dsel}, 8'h15);
    defaults;
    for (int i = 0; i < 6; i++) begin
      d = i < 4 ? {2'b11, {3{i[1:0]}}} : 8'($random(seed));
      wr8(8'h42, d);
      u_host.rd(8'h42, rd);
      chk("discharge", rd, {2'b00, d[5:0]});
      chk("dsel", {2'b00, dsel}, {2'b00, d[5:0]});
    end
    rail_en <= 3'b101;
    cy(6);
    wr8(8'h42, 8'h3f);
    chk("forced", {2'b00, dsel}, 8'h0c);
    rail_en <= 3'b000;
    cy(6);
    chk("released", {2'b00, dsel}, 8'h0c);
    wr8(8'h42, 8'h3f);
    chk("rewritten", {2'b00, dsel}, 8'h3f);
    for (int c = 0; c < 8; c++) begin
      wr8(8'h43, {5'h1f, 3'(c)});
      u_host.rd(8'h43, rd);
      chk("delay reg", rd, {5'h0, 3'(c)});
      in_reg <= {4'($random(seed)), 4'h7};
      cy(20);
      chk("held off", {7'h0, go3}, 8'h0);
      in_reg[3] <= 1'b1;
      n = 0;
      while (go3 !== 1'b1 && n < 500) begin
        @(negedge sys_clk);
        n++;
      end
      chk("delay", 8'(n >= dly(c) - 2 && n <= dly(c) + 5), 8'h1);
      cy(1);
      in_reg <= 8'h00;
      cy(4);
      chk("pg drop", {7'h0, go3}, 8'h0);
    end
    rst(2'h1, 1'b0);
    lvl_in <= 1'b1;
    cy(20);
    chk("level", {7'h0, go3}, 8'h1);
    rst(2'h2, 1'b0);
    in_reg <= 8'hff;
    for (int k = 0; k < 4; k++) begin
      bus_lvl <= k[0];
      cy(4);
      chk("bus level", {7'h0, go3}, {7'h0, k[0]});
    end
    // termination use keeps the delay path even in bus mode
    vtt <= 1'b1;
    bus_lvl <= 1'b0;
    cy(30);
    chk("vtt delay path", {7'h0, go3}, 8'h1);
    rst(2'h0, 1'b0);
    sleep_run;
    rst(2'h0, 1'b1);
    sleep_run;
    wr8(8'h42, 8'h2a);
    wr8(8'h91, 8'h00);
    u_host.rd(8'h42, rd);
    chk("no action", rd, 8'h2a);
    wr8(8'h91, 8'hff);
    cy(40);
    defaults;
    u_host.rd(8'h91, rd);
    chk("off bit", rd, 8'h00);
    final_report;
  end
endmodule
